/* File: logic/dtcb_top.sv */
// dual 8/16-bit timer with apb register bank
`timescale 1ns/100ps
`default_nettype none
`include "dtcb_consts.svh"
module dtcb_top (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator ticks and event pin
  input wire logic low_speed_osc,
  input wire logic high_speed_osc,
  input wire logic external_count_pin,
  // outputs
  output logic divided_underflow_output,
  output logic irq
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic regHit(input logic [19:0] a,
                                 input logic [17:0] idx);
    regHit = (a[1:0] == 2'h0) && (a[19:2] == idx);
  endfunction : regHit
  function automatic logic [5:0] divMask(input logic [1:0] sel);
    case (sel)
      2'h3: divMask = 6'h3f;
      2'h2: divMask = 6'h0f;
      2'h1: divMask = 6'h03;
      default: divMask = 6'h00;
    endcase
  endfunction : divMask
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  dtcb_pkg::dtcb_gcfg_s gcfg;
  dtcb_pkg::dtcb_tctl_s ctlA;
  dtcb_pkg::dtcb_tctl_s ctlB;
  logic [7:0] reloadA, reloadB, cntA, cntB;
  logic [1:0] irqStat, irqMask;
  logic wrEn, rdSetup, mapped;
  logic loadA, loadB, underA, underB, under16, stopA, stopB;
  logic tickA, tickB, selUnder, tone;
  assign wrEn = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign mapped = regHit(paddr, `DTCB_IDX_GLOBAL)
               || regHit(paddr, `DTCB_IDX_CTRL_A)
               || regHit(paddr, `DTCB_IDX_CTRL_B)
               || regHit(paddr, `DTCB_IDX_RELOAD_A)
               || regHit(paddr, `DTCB_IDX_RELOAD_B)
               || regHit(paddr, `DTCB_IDX_COUNT_A)
               || regHit(paddr, `DTCB_IDX_COUNT_B)
               || regHit(paddr, `DTCB_IDX_IRQ_STAT)
               || regHit(paddr, `DTCB_IDX_IRQ_MASK);
  // zero wait states; unmapped words answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign loadA = wrEn && regHit(paddr, `DTCB_IDX_CTRL_A)
              && pwdata[`DTCB_B_LOAD];  // [RULE15]
  assign loadB = wrEn && regHit(paddr, `DTCB_IDX_CTRL_B)
              && pwdata[`DTCB_B_LOAD];  // [RULE15]

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gcfg <= 5'(`DTCB_RST_CTRL);  // [RULE1]
    end else if (wrEn && regHit(paddr, `DTCB_IDX_GLOBAL)) begin
      gcfg <= pwdata[4:0];
    end
  end
  // run bit: hardware stop beats a same-cycle software write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctlA <= 7'(`DTCB_RST_CTRL);  // [RULE1]
    end else if (wrEn && regHit(paddr, `DTCB_IDX_CTRL_A)) begin
      ctlA <= {pwdata[7:2], pwdata[`DTCB_B_RUN] && !stopA};  // [RULE9]
    end else if (stopA) begin
      ctlA.run <= 1'b0;  // [RULE16]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctlB <= 7'(`DTCB_RST_CTRL);  // [RULE1]
    end else if (wrEn && regHit(paddr, `DTCB_IDX_CTRL_B)) begin
      // upper three bits of timer b control are not implemented
      ctlB <= {2'h0, 1'b0, pwdata[4:2],
               pwdata[`DTCB_B_RUN] && !stopB};  // [RULE10]
    end else if (stopB) begin
      ctlB.run <= 1'b0;  // [RULE16]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reloadA <= `DTCB_RST_RELOAD;
      reloadB <= `DTCB_RST_RELOAD;
      irqMask <= 2'h0;
    end else if (wrEn) begin
      if (regHit(paddr, `DTCB_IDX_RELOAD_A)) begin
        reloadA <= pwdata[7:0];
      end else if (regHit(paddr, `DTCB_IDX_RELOAD_B)) begin
        reloadB <= pwdata[7:0];
      end else if (regHit(paddr, `DTCB_IDX_IRQ_MASK)) begin
        irqMask <= pwdata[1:0];
      end
    end
  end

  // sticky flags: a new underflow wins over a write-one clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat <= 2'h0;
    end else begin
      irqStat <= (irqStat & ~((wrEn && regHit(paddr, `DTCB_IDX_IRQ_STAT))
                 ? pwdata[1:0] : 2'h0))
               | {underB, underA && !gcfg.wide};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat & irqMask);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0;
    end else if (rdSetup) begin
      if (regHit(paddr, `DTCB_IDX_GLOBAL)) begin
        prdata <= {27'h0, gcfg};
      end else if (regHit(paddr, `DTCB_IDX_CTRL_A)) begin
        prdata <= {24'h0, ctlA[6:1], 1'b0, ctlA.run};  // [RULE15]
      end else if (regHit(paddr, `DTCB_IDX_CTRL_B)) begin
        prdata <= {24'h0, ctlB[6:1], 1'b0, ctlB.run};  // [RULE15]
      end else if (regHit(paddr, `DTCB_IDX_RELOAD_A)) begin
        prdata <= {24'h0, reloadA};
      end else if (regHit(paddr, `DTCB_IDX_RELOAD_B)) begin
        prdata <= {24'h0, reloadB};
      end else if (regHit(paddr, `DTCB_IDX_COUNT_A)) begin
        prdata <= {24'h0, cntA};
      end else if (regHit(paddr, `DTCB_IDX_COUNT_B)) begin
        prdata <= {24'h0, cntB};
      end else if (regHit(paddr, `DTCB_IDX_IRQ_STAT)) begin
        prdata <= {30'h0, irqStat};
      end else if (regHit(paddr, `DTCB_IDX_IRQ_MASK)) begin
        prdata <= {30'h0, irqMask};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // prescalers and event input
  // ---------------------------------------------------------------
  logic lsQ, hsQ, srcA, srcB, evQ, evPrev, nrLvl, evUse;
  logic [5:0] pscA, pscB;
  logic [7:0] nrCnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lsQ <= 1'b0;
      hsQ <= 1'b0;
      evQ <= 1'b0;
      evPrev <= 1'b0;
    end else begin
      lsQ <= low_speed_osc;
      hsQ <= high_speed_osc;
      evQ <= external_count_pin;
      evPrev <= evUse;
    end
  end
  assign srcA = gcfg.ckA ? (high_speed_osc && !hsQ)
                         : (low_speed_osc && !lsQ);  // [RULE2]
  assign srcB = gcfg.ckB ? (high_speed_osc && !hsQ)
                         : (low_speed_osc && !lsQ);  // [RULE3]

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pscA <= 6'h00;
      pscB <= 6'h00;
    end else begin
      pscA <= srcA ? pscA + 6'h01 : pscA;
      pscB <= srcB ? pscB + 6'h01 : pscB;
    end
  end

  // filtered level follows the pin only after it holds steady
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nrCnt <= 8'h00;
      nrLvl <= 1'b0;
    end else if (evQ == nrLvl) begin
      nrCnt <= 8'h00;
    end else if (nrCnt == `DTCB_NR_CYCLES) begin
      nrLvl <= evQ;
      nrCnt <= 8'h00;
    end else begin
      nrCnt <= nrCnt + 8'h01;
    end
  end
  assign evUse = ctlA.funcSelect ? nrLvl : evQ;  // [RULE7]

  always_comb begin
    if (ctlA.countSource) begin  // [RULE6]
      tickA = (evUse != evPrev) && (evUse == ctlA.pol);  // [RULE8]
    end else begin
      tickA = srcA && ((pscA & divMask(ctlA.div)) == divMask(ctlA.div))
           && (!ctlA.funcSelect || (evQ == ctlA.pol));  // [RULE4] [RULE14]
    end
  end
  // in wide mode timer b is the upper byte, stepped by a's borrow
  assign tickB = gcfg.wide ? underA
    : (srcB && ((pscB & divMask(ctlB.div)) == divMask(ctlB.div)));
  // [RULE5] [RULE11]

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  assign underA = ctlA.run && tickA && (cntA == 8'h00);  // [RULE9]
  assign under16 = gcfg.wide && underA && (cntB == 8'h00);  // [RULE11]
  assign underB = gcfg.wide ? under16
                : (ctlB.run && tickB && (cntB == 8'h00));  // [RULE10]
  assign stopA = gcfg.wide ? (under16 && !ctlA.repeatMode)
               : (underA && !ctlA.repeatMode);  // [RULE16]
  assign stopB = !gcfg.wide && underB && !ctlB.repeatMode;  // [RULE16]

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cntA <= 8'h00;
    end else if (loadA || underA) begin
      cntA <= reloadA;  // [RULE15] [RULE16]
    end else if (ctlA.run && tickA) begin
      cntA <= cntA - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cntB <= 8'h00;
    end else if (loadB || underB) begin
      cntB <= reloadB;  // [RULE15] [RULE16]
    end else if ((gcfg.wide || ctlB.run) && tickB) begin
      cntB <= cntB - 8'h01;  // [RULE11]
    end
  end

  // ---------------------------------------------------------------
  // tone output
  // ---------------------------------------------------------------
  assign selUnder = (gcfg.toneSrc || gcfg.wide) ? underB : underA;
  // [RULE12]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tone <= 1'b0;
      divided_underflow_output <= 1'b1;
    end else begin
      tone <= tone ^ selUnder;  // [RULE13]
      divided_underflow_output <= gcfg.toneEn ? (tone ^ selUnder)
                                              : 1'b1;  // [RULE13]
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_strobe_reads_zero;
    @(posedge clk) disable iff (!arst_n)
    rdSetup && regHit(paddr, `DTCB_IDX_CTRL_A) |=> !prdata[1];
  endproperty
  a_strobe_reads_zero: assert property (p_strobe_reads_zero) // [RULE15]
    else $error("load strobe read back as one");
  property p_load_b;
    @(posedge clk) disable iff (!arst_n)
    loadB |=> cntB == $past(reloadB);
  endproperty
  a_load_b: assert property (p_load_b) // [RULE15]
    else $error("load strobe did not copy reload");
  property p_one_shot;
    @(posedge clk) disable iff (!arst_n)
    underA && !gcfg.wide && !ctlA.repeatMode && !wrEn |=> !ctlA.run;
  endproperty
  a_one_shot: assert property (p_one_shot) // [RULE16]
    else $error("one-shot timer kept running");
  property p_stopped_holds;
    @(posedge clk) disable iff (!arst_n)
    !ctlA.run && !loadA |=> $stable(cntA);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds) // [RULE9]
    else $error("stopped timer changed");
  property p_tone_off_high;
    @(posedge clk) disable iff (!arst_n)
    !gcfg.toneEn ##1 !gcfg.toneEn |-> divided_underflow_output;
  endproperty
  a_tone_off_high: assert property (p_tone_off_high) // [RULE13]
    else $error("tone pin low while disabled");
  property p_tone_toggle;
    @(posedge clk) disable iff (!arst_n)
    selUnder |=> tone != $past(tone);
  endproperty
  a_tone_toggle: assert property (p_tone_toggle) // [RULE13]
    else $error("tone did not toggle on underflow");
  property p_wide_no_flag_a;
    @(posedge clk) disable iff (!arst_n)
    gcfg.wide && underA && !irqStat[0] |=> !irqStat[0];
  endproperty
  a_wide_no_flag_a: assert property (p_wide_no_flag_a) // [RULE11]
    else $error("timer a flag set in wide mode");
  property p_wide_reload;
    @(posedge clk) disable iff (!arst_n)
    under16 |=> cntA == $past(reloadA) && cntB == $past(reloadB);
  endproperty
  a_wide_reload: assert property (p_wide_reload) // [RULE11]
    else $error("wide counter did not reload");
  property p_pw_level;
    @(posedge clk) disable iff (!arst_n)
    !ctlA.countSource && ctlA.funcSelect && evQ != ctlA.pol && !loadA
    |=> $stable(cntA);
  endproperty
  a_pw_level: assert property (p_pw_level) // [RULE14]
    else $error("pulse width counted at wrong level");
  c_under16: cover property (@(posedge clk) disable iff (!arst_n)
    under16);
  c_event_tick: cover property (@(posedge clk) disable iff (!arst_n)
    ctlA.countSource && ctlA.funcSelect && tickA);
  c_flag_race: cover property (@(posedge clk) disable iff (!arst_n)
    underB && wrEn && regHit(paddr, `DTCB_IDX_IRQ_STAT));
endmodule : dtcb_top
`default_nettype wire

/* File: inc/dtcb_consts.svh */
// constants of the dual timer control bank
// Function
// RULE1 - three 8-bit control registers, zero at reset
// RULE2 - global bit 0 picks prescaler A clock
// RULE3 - global bit 1 picks prescaler B clock
// RULE4 - timer A bits 4:3 divide by 1/4/16/64
// RULE5 - timer B bits 4:3 same divide encoding
// RULE6 - timer A bit 7 selects event counting
// RULE7 - timer A bit 6 inserts noise rejecter
// RULE8 - timer A bit 5 picks counted edge
// RULE9 - timer A bit 0 runs timer A
// RULE10 - timer B bit 0 runs timer B
// RULE11 - wide mode joins both into 16 bits
// RULE12 - tone source A or B, wide uses combined
// RULE13 - tone toggles per underflow, gated high
// RULE14 - pulse width counts at chosen level
// RULE15 - load strobe copies reload, reads zero
// RULE16 - repeat reloads, one-shot clears run bit
`ifndef DTCB_CONSTS_SVH
`define DTCB_CONSTS_SVH
// register indices; byte address is four times the index
`define DTCB_IDX_GLOBAL 18'h0ff30
`define DTCB_IDX_CTRL_A 18'h0ff31
`define DTCB_IDX_CTRL_B 18'h0ff32
`define DTCB_IDX_RELOAD_A 18'h0ff33
`define DTCB_IDX_RELOAD_B 18'h0ff34
`define DTCB_IDX_COUNT_A 18'h0ff35
`define DTCB_IDX_COUNT_B 18'h0ff36
`define DTCB_IDX_IRQ_STAT 18'h0ff37
`define DTCB_IDX_IRQ_MASK 18'h0ff38
// field positions
`define DTCB_B_CLK_A 0
`define DTCB_B_CLK_B 1
`define DTCB_B_TONE_EN 2
`define DTCB_B_TONE_SRC 3
`define DTCB_B_WIDE 4
`define DTCB_B_RUN 0
`define DTCB_B_LOAD 1
`define DTCB_B_REPEAT 2
`define DTCB_B_DIV_LO 3
`define DTCB_B_DIV_HI 4
`define DTCB_B_POL 5
`define DTCB_B_FUNC 6
`define DTCB_B_EVENT 7
// reset values
`define DTCB_RST_CTRL 8'h00
`define DTCB_RST_RELOAD 8'hff
// noise rejecter settle time in clock cycles
`define DTCB_NR_CYCLES 8'h10
`endif

/* File: inc/dtcb_pkg.sv */
// types of the dual timer control bank
`default_nettype none
package dtcb_pkg;
  typedef struct packed {
    logic countSource;
    logic funcSelect;
    logic pol;
    logic [1:0] div;
    logic repeatMode;
    logic run;
  } dtcb_tctl_s;
  typedef struct packed {
    logic wide;
    logic toneSrc;
    logic toneEn;
    logic ckB;
    logic ckA;
  } dtcb_gcfg_s;
endpackage : dtcb_pkg
`default_nettype wire

/* File: test/dtcb_tb_top.sv */
// self-checking testbench of the dual timer control bank
`timescale 1ns/100ps
`default_nettype none
`include "dtcb_consts.svh"
module dtcb_tb_top;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [19:0] paddr = 20'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic loOsc = 1'b0;
  logic hiOsc = 1'b0;
  logic pin = 1'b0;
  logic tone;
  logic irq;
  logic lastErr;
  logic [31:0] junk;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  dtcb_top dut_u (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_osc(loOsc), .high_speed_osc(hiOsc),
    .external_count_pin(pin), .divided_underflow_output(tone), .irq(irq));
  always #2.5 clk = ~clk;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // ceiling well above the longest expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [17:0] i,
                     input logic [7:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [17:0] i, input logic [7:0] d);
    apb(1'b1, i, d, junk);
  endtask : wr
  task automatic rdc(input string nm, input logic [17:0] i,
                     input logic [7:0] e);
    logic [31:0] r;
    apb(1'b0, i, 8'h00, r);
    chk(nm, {24'h000000, e}, r);
  endtask : rdc
  // k source ticks; oscillator kept slower than half the clock
  task automatic tick(input logic hs, input int k);
    repeat (k) begin
      if (hs) hiOsc <= 1'b1;
      else loOsc <= 1'b1;
      repeat (2) @(posedge clk);
      hiOsc <= 1'b0;
      loOsc <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : tick
  // ticks between two tone toggles; the first toggle only aligns
  task automatic meas(input logic hs, output int m);
    logic t;
    int k;
    t = tone;
    k = 0;
    while (tone === t && k < 600) begin
      tick(hs, 1);
      k++;
    end
    t = tone;
    m = 0;
    while (tone === t && m < 600) begin
      tick(hs, 1);
      m++;
    end
  endtask : meas
  task automatic hold_pin(input logic v, input int k);
    pin <= v;
    repeat (k) @(posedge clk);
  endtask : hold_pin
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdc("global", `DTCB_IDX_GLOBAL, 8'h00);
    rdc("ctrlA", `DTCB_IDX_CTRL_A, 8'h00);
    rdc("ctrlB", `DTCB_IDX_CTRL_B, 8'h00);
    chk("tone idle", 32'h1, {31'h0, tone});
  endtask : t_reset
  task automatic t_regs();
    wr(`DTCB_IDX_CTRL_A, 8'hfa);
    rdc("ctrlA rw", `DTCB_IDX_CTRL_A, 8'hf8);
    wr(`DTCB_IDX_CTRL_B, 8'hfe);
    rdc("ctrlB rw", `DTCB_IDX_CTRL_B, 8'h1c);
    wr(`DTCB_IDX_CTRL_A, 8'h00);
    wr(`DTCB_IDX_CTRL_B, 8'h00);
    wr(`DTCB_IDX_RELOAD_A, 8'h5a);
    rdc("countA idle", `DTCB_IDX_COUNT_A, `DTCB_RST_RELOAD);
    wr(`DTCB_IDX_CTRL_A, 8'h02);
    rdc("countA load", `DTCB_IDX_COUNT_A, 8'h5a);
    rdc("unmapped", 18'h0ff39, 8'h00);
    chk("slverr", 32'h1, {31'h0, lastErr});
    chk("pready", 32'h1, {31'h0, pready});
  endtask : t_regs
  task automatic t_div();
    wr(`DTCB_IDX_GLOBAL, 8'h05);
    wr(`DTCB_IDX_RELOAD_A, 8'h01);
    wr(`DTCB_IDX_CTRL_A, 8'h02);
    for (int d = 0; d < 4; d++) begin
      wr(`DTCB_IDX_CTRL_A, 8'h05 | (d[7:0] << 3));
      meas(1'b1, n);
      chk("div period", 2 << (2 * d), n);
    end
    wr(`DTCB_IDX_GLOBAL, 8'h04);
    wr(`DTCB_IDX_CTRL_A, 8'h05);
    meas(1'b0, n);
    chk("low osc period", 2, n);
  endtask : t_div
  task automatic t_timer_b();
    wr(`DTCB_IDX_CTRL_A, 8'h00);
    wr(`DTCB_IDX_GLOBAL, 8'h0e);
    wr(`DTCB_IDX_RELOAD_B, 8'h00);
    wr(`DTCB_IDX_CTRL_B, 8'h02);
    wr(`DTCB_IDX_CTRL_B, 8'h15);
    meas(1'b1, n);
    chk("B period", 16, n);
    wr(`DTCB_IDX_CTRL_B, 8'h00);
  endtask : t_timer_b
  task automatic t_wide();
    // source select left on A: combined underflow must still drive it
    wr(`DTCB_IDX_GLOBAL, 8'h15);
    wr(`DTCB_IDX_RELOAD_A, 8'h01);
    wr(`DTCB_IDX_RELOAD_B, 8'h01);
    wr(`DTCB_IDX_CTRL_B, 8'h02);
    wr(`DTCB_IDX_CTRL_A, 8'h02);
    wr(`DTCB_IDX_CTRL_A, 8'h05);
    meas(1'b1, n);
    chk("wide period", 4, n);
    wr(`DTCB_IDX_CTRL_A, 8'h00);
  endtask : t_wide
  task automatic t_oneshot();
    wr(`DTCB_IDX_GLOBAL, 8'h01);
    repeat (2) @(posedge clk);
    chk("tone off", 32'h1, {31'h0, tone});
    wr(`DTCB_IDX_RELOAD_A, 8'h02);
    wr(`DTCB_IDX_CTRL_A, 8'h02);
    wr(`DTCB_IDX_IRQ_STAT, 8'h03);
    wr(`DTCB_IDX_IRQ_MASK, 8'h01);
    wr(`DTCB_IDX_CTRL_A, 8'h01);
    tick(1'b1, 2);
    rdc("run kept", `DTCB_IDX_CTRL_A, 8'h01);
    tick(1'b1, 1);
    rdc("run cleared", `DTCB_IDX_CTRL_A, 8'h00);
    rdc("stat A", `DTCB_IDX_IRQ_STAT, 8'h01);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(`DTCB_IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`DTCB_IDX_IRQ_MASK, 8'h01);
    wr(`DTCB_IDX_IRQ_STAT, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc("stat clear", `DTCB_IDX_IRQ_STAT, 8'h00);
  endtask : t_oneshot
  task automatic t_event();
    wr(`DTCB_IDX_GLOBAL, 8'h00);
    wr(`DTCB_IDX_RELOAD_A, 8'h09);
    for (int p = 0; p < 2; p++) begin
      wr(`DTCB_IDX_CTRL_A, 8'h02);
      wr(`DTCB_IDX_CTRL_A, 8'h85 | (p[7:0] << 5));
      hold_pin(1'b1, 30);
      rdc("after rise", `DTCB_IDX_COUNT_A, p ? 8'h08 : 8'h09);
      hold_pin(1'b0, 30);
      rdc("after fall", `DTCB_IDX_COUNT_A, 8'h08);
    end
    // glitches shorter than the settle time must vanish
    wr(`DTCB_IDX_CTRL_A, 8'h02);
    wr(`DTCB_IDX_CTRL_A, 8'he5);
    repeat (3) begin
      hold_pin(1'b1, 5);
      hold_pin(1'b0, 5);
    end
    repeat (30) @(posedge clk);
    rdc("glitch", `DTCB_IDX_COUNT_A, 8'h09);
    hold_pin(1'b1, 30);
    rdc("filtered", `DTCB_IDX_COUNT_A, 8'h08);
    hold_pin(1'b0, 30);
  endtask : t_event
  task automatic t_pulse();
    wr(`DTCB_IDX_GLOBAL, 8'h01);
    wr(`DTCB_IDX_CTRL_A, 8'h02);
    wr(`DTCB_IDX_CTRL_A, 8'h65);
    tick(1'b1, 3);
    rdc("pw low", `DTCB_IDX_COUNT_A, 8'h09);
    hold_pin(1'b1, 5);
    tick(1'b1, 3);
    rdc("pw high", `DTCB_IDX_COUNT_A, 8'h06);
    hold_pin(1'b0, 5);
    wr(`DTCB_IDX_CTRL_A, 8'h00);
  endtask : t_pulse
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_div();
    t_timer_b();
    t_wide();
    t_oneshot();
    t_event();
    t_pulse();
    give_verdict();
  end
endmodule : dtcb_tb_top
`default_nettype wire
